// ===== hdl/out_channel_consts.vh
// Register offsets, field positions and reset values of the output channel divider.
`ifndef OUT_CHANNEL_CONSTS_VH
`define OUT_CHANNEL_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CH2_OUTPUT_CONTROL 10'h198
`define ADDR_CH3_CYCLE_COUNTS 10'h199
`define ADDR_CH3_DIVIDER_CONTROL 10'h19a
`define ADDR_CH3_OUTPUT_CONTROL 10'h19b
`define ADDR_CLK_INPUT_CONTROL 10'h1e1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CNT_LOW_MSB 7
`define CNT_LOW_LSB 4
`define CNT_HIGH_MSB 3
`define CNT_HIGH_LSB 0
`define DCTL_BYPASS 7
`define DCTL_IGNORE_SYNC 6
`define DCTL_FORCE_HIGH 5
`define DCTL_START_HIGH 4
`define DCTL_PHASE_MSB 3
`define DCTL_PHASE_LSB 0
`define OCTL_POWER_DOWN 2
`define OCTL_DIRECT 1
`define OCTL_DUTY_CORR_OFF 0
`define CLKIN_VCO_DIV_BYPASS 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CYCLE_COUNTS 8'h00
`define RST_DIVIDER_CONTROL 8'h00
`define RST_OUTPUT_CONTROL 8'h00
`define RST_CLK_INPUT_CONTROL 8'h00

`endif

// ===== hdl/divider_core.v
// Counter core that shapes the divided clock from input clock edges.
`timescale 1ns/100ps
`include "out_channel_consts.vh"

module divider_core #(
    parameter CW = 4
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_nrst,
    // Control
    input wire i_in_edge,
    input wire i_sync_hold,
    input wire [CW-1:0] i_low_cycles,
    input wire [CW-1:0] i_high_cycles,
    input wire [CW-1:0] i_phase,
    input wire i_start_high,
    // Divided level
    output reg o_div_level
);

reg [CW-1:0] cnt_r;
reg [CW-1:0] phase_r;

// ----------------------------------------
// Divider
// ----------------------------------------
always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        cnt_r <= {CW{1'b0}};
        phase_r <= {CW{1'b0}};
        o_div_level <= 1'b0;
    end else if (i_sync_hold) begin
        // Held at the start level until sync is released. (see R14)
        cnt_r <= {CW{1'b0}};
        phase_r <= i_phase; // see R8
        o_div_level <= i_start_high; // see R7
    end else if (i_in_edge) begin
        if (phase_r != {CW{1'b0}}) begin
            phase_r <= phase_r - 1'b1; // see R8
        end else if (cnt_r == (o_div_level ? i_high_cycles : i_low_cycles)) begin
            // Each half lasts its count plus one input cycles. (see R1) (see R2)
            cnt_r <= {CW{1'b0}};
            o_div_level <= ~o_div_level;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
end

endmodule

// ===== hdl/output_channel_divider.v
// Channel 3 divider, output routing and configuration registers.
//
// Behaviour
// R1: Output stays low for low-cycles field plus one input cycles; reset zero.
// R2: Output stays high for high-cycles field plus one input cycles; reset zero.
// R3: Bypass bit powers down divider and passes input clock to output.
// R4: Divider obeys sync unless the ignore-sync bit is set.
// R5: With ignore-sync set, output is static: low, or start-high level if forced.
// R6: Force bit has no effect while divider is bypassed.
// R7: Start-high bit selects the level the divider output begins at.
// R8: Four-bit phase offset delays divider start; resets to zero.
// R9: Channel power-down puts all three outputs into safe power-down.
// R10: Direct bit routes input clock to outputs unless VCO divider bypassed.
// R11: Channel correction-disable bit clear enables duty cycle correction.
// R12: Preceding channel's bit 0 likewise controls its duty cycle correction.
// R13: VCO-divider bypass bit selects use or bypass; gates direct routing.
// R14: After sync, restart at start level after phase offset; period is sum.
`timescale 1ns/100ps
`include "out_channel_consts.vh"

module output_channel_divider #(
    parameter AW = 10,
    parameter CW = 4
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_nrst,
    // Serial control port register access
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [AW-1:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    // Distribution clock and chip-level sync pins
    input wire i_dist_clk,
    input wire i_sync_n,
    // Channel outputs
    output reg o_group3_first_output,
    output reg o_group3_second_output,
    output reg o_group3_third_output,
    output reg o_group3_power_down,
    output reg o_duty_cycle_correction_en,
    output reg o_ch2_duty_cycle_correction_en,
    output reg o_vco_divider_bypass
);

reg [7:0] cycle_counts_r;
reg [7:0] divider_control_r;
reg [2:0] output_control_r;
reg ch2_duty_corr_off_r;
reg vco_div_bypass_r;
reg [1:0] clk_sync_r;
reg [1:0] sync_sync_r;
reg clk_prev_r;
reg out_nxt;
wire in_level;
wire in_edge;
wire sync_active;
wire div_level;
wire bypass;
wire ignore_sync;
wire direct;
wire [4:0] reg_sel;

// ----------------------------------------
// Address decode
// ----------------------------------------
// One select is shared by the write and the read path, so both always agree
// on the register map and an unmapped address selects nothing at all.
localparam [4:0] SEL_CH2_CTL = 5'h01;
localparam [4:0] SEL_COUNTS = 5'h02;
localparam [4:0] SEL_DIV_CTL = 5'h04;
localparam [4:0] SEL_OUT_CTL = 5'h08;
localparam [4:0] SEL_CLKIN = 5'h10;

function [4:0] reg_select;
    input [AW-1:0] addr;
    begin
        case (addr)
            `ADDR_CH2_OUTPUT_CONTROL: reg_select = SEL_CH2_CTL;
            `ADDR_CH3_CYCLE_COUNTS: reg_select = SEL_COUNTS;
            `ADDR_CH3_DIVIDER_CONTROL: reg_select = SEL_DIV_CTL;
            `ADDR_CH3_OUTPUT_CONTROL: reg_select = SEL_OUT_CTL;
            `ADDR_CLK_INPUT_CONTROL: reg_select = SEL_CLKIN;
            default: reg_select = 5'h00;
        endcase
    end
endfunction

assign reg_sel = reg_select(i_reg_addr);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// The distribution clock is treated as a level sampled here, so it must run
// well below half of the system clock rate for edges not to be lost.
always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        clk_sync_r <= 2'b00;
        sync_sync_r <= 2'b11;
        clk_prev_r <= 1'b0;
    end else begin
        clk_sync_r <= {clk_sync_r[0], i_dist_clk};
        sync_sync_r <= {sync_sync_r[0], i_sync_n};
        clk_prev_r <= clk_sync_r[1];
    end
end

assign in_level = clk_sync_r[1];
assign in_edge = clk_sync_r[1] & ~clk_prev_r;
assign bypass = divider_control_r[`DCTL_BYPASS];
assign ignore_sync = divider_control_r[`DCTL_IGNORE_SYNC];
assign direct = output_control_r[`OCTL_DIRECT] & ~vco_div_bypass_r; // see R10 see R13
assign sync_active = ~sync_sync_r[1] & ~ignore_sync; // see R4

// ----------------------------------------
// Register writes
// ----------------------------------------
always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        cycle_counts_r <= `RST_CYCLE_COUNTS; // see R1 see R2
        divider_control_r <= `RST_DIVIDER_CONTROL;
        output_control_r <= 3'b000;
        ch2_duty_corr_off_r <= 1'b0;
        vco_div_bypass_r <= 1'b0;
    end else if (i_reg_wr) begin
        case (reg_sel)
            SEL_CH2_CTL: begin
                ch2_duty_corr_off_r <= i_reg_wdata[`OCTL_DUTY_CORR_OFF]; // see R12
            end
            SEL_COUNTS: begin
                cycle_counts_r <= i_reg_wdata;
            end
            SEL_DIV_CTL: begin
                divider_control_r <= i_reg_wdata;
            end
            SEL_OUT_CTL: begin
                output_control_r <= i_reg_wdata[2:0];
            end
            SEL_CLKIN: begin
                vco_div_bypass_r <= i_reg_wdata[`CLKIN_VCO_DIV_BYPASS]; // see R13
            end
            default: begin
            end
        endcase
    end
end

// ----------------------------------------
// Register reads
// ----------------------------------------
// Unused bits and unmapped addresses read as zero.
always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        o_reg_rdata <= 8'h00;
        o_reg_rvalid <= 1'b0;
    end else begin
        o_reg_rvalid <= i_reg_rd;
        if (i_reg_rd) begin
            case (reg_sel)
                SEL_CH2_CTL: o_reg_rdata <= {7'h00, ch2_duty_corr_off_r};
                SEL_COUNTS: o_reg_rdata <= cycle_counts_r;
                SEL_DIV_CTL: o_reg_rdata <= divider_control_r;
                SEL_OUT_CTL: o_reg_rdata <= {5'h00, output_control_r};
                SEL_CLKIN: o_reg_rdata <= {7'h00, vco_div_bypass_r};
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end
end

// ----------------------------------------
// Divider
// ----------------------------------------
divider_core #(
    .CW(CW)
) u_divider_core (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_in_edge(in_edge),
    .i_sync_hold(sync_active | bypass), // see R3 see R14
    .i_low_cycles(cycle_counts_r[`CNT_LOW_MSB:`CNT_LOW_LSB]),
    .i_high_cycles(cycle_counts_r[`CNT_HIGH_MSB:`CNT_HIGH_LSB]),
    .i_phase(divider_control_r[`DCTL_PHASE_MSB:`DCTL_PHASE_LSB]),
    .i_start_high(divider_control_r[`DCTL_START_HIGH]),
    .o_div_level(div_level)
);

// ----------------------------------------
// Output routing
// ----------------------------------------
always @* begin
    if (output_control_r[`OCTL_POWER_DOWN]) begin
        out_nxt = 1'b0; // see R9
    end else if (direct || bypass) begin
        // Force is not honoured here; driver polarity is downstream. (see R3) (see R6)
        out_nxt = in_level;
    end else if (ignore_sync) begin
        out_nxt = divider_control_r[`DCTL_FORCE_HIGH] &
                  divider_control_r[`DCTL_START_HIGH]; // see R5
    end else begin
        out_nxt = div_level;
    end
end

always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        o_group3_first_output <= 1'b0;
        o_group3_second_output <= 1'b0;
        o_group3_third_output <= 1'b0;
        o_group3_power_down <= 1'b0;
        o_duty_cycle_correction_en <= 1'b1;
        o_ch2_duty_cycle_correction_en <= 1'b1;
        o_vco_divider_bypass <= 1'b0;
    end else begin
        o_group3_first_output <= out_nxt;
        o_group3_second_output <= out_nxt;
        o_group3_third_output <= out_nxt;
        o_group3_power_down <= output_control_r[`OCTL_POWER_DOWN]; // see R9
        o_duty_cycle_correction_en <= ~output_control_r[`OCTL_DUTY_CORR_OFF]; // see R11
        o_ch2_duty_cycle_correction_en <= ~ch2_duty_corr_off_r; // see R12
        o_vco_divider_bypass <= vco_div_bypass_r; // see R13
    end
end

endmodule

// ===== sim/output_channel_divider_monitor.sv
// Port assertions for the channel divider.
`timescale 1ns/100ps
module output_channel_divider_monitor (
    // Clock, reset and register port
    input wire i_clk_sys, input wire i_nrst, input wire i_reg_wr, input wire i_reg_rd,
    input wire [9:0] i_reg_addr, input wire [7:0] i_reg_wdata, input wire [7:0] o_reg_rdata,
    input wire o_reg_rvalid, input wire i_dist_clk, input wire i_sync_n,
    // Channel outputs
    input wire o_group3_first_output, input wire o_group3_second_output,
    input wire o_group3_third_output, input wire o_group3_power_down,
    input wire o_duty_cycle_correction_en, input wire o_ch2_duty_cycle_correction_en,
    input wire o_vco_divider_bypass
);
// ----
// Shadow registers
// ----
// Channel outputs are compared with the shadow registers only after a quiet spell, so the design's pipeline depth does not matter.
logic [7:0] div_r, ctl_r, prv_r, ckn_r;
logic [2:0] q_r;
wire ok = q_r > 3'h2;
wire stat = q_r == 3'h7 && div_r[6] && !div_r[7] && !ctl_r[2] && !(ctl_r[1] && !ckn_r[0]);
always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        {div_r, ctl_r, prv_r, ckn_r} <= 32'h0;
        q_r <= 3'h7;
    end else begin
        q_r <= i_reg_wr ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
        if (i_reg_wr && i_reg_addr == 10'h19a) div_r <= i_reg_wdata;
        if (i_reg_wr && i_reg_addr == 10'h19b) ctl_r <= i_reg_wdata;
        if (i_reg_wr && i_reg_addr == 10'h198) prv_r <= i_reg_wdata;
        if (i_reg_wr && i_reg_addr == 10'h1e1) ckn_r <= i_reg_wdata;
    end
end
default clocking @(posedge i_clk_sys); endclocking
default disable iff (!i_nrst);
sequence pd_held;
    o_group3_power_down [*3];
endsequence
AST_RVALID: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read answer missing");
AST_RVALID_CAUSE: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read answer without read");
AST_RDATA_DIV: assert property (i_reg_rd && i_reg_addr == 10'h19a |=> o_reg_rdata == $past(div_r))
    else $error("divider control readback");
AST_RDATA_CTL: assert property (i_reg_rd && i_reg_addr == 10'h19b |=> o_reg_rdata == {5'h0, $past(ctl_r[2:0])})
    else $error("output control readback");
AST_PD: assert property (ok |-> o_group3_power_down == ctl_r[2])
    else $error("power-down level");
AST_PD_LOW: assert property (pd_held |-> !o_group3_first_output)
    else $error("output active in power-down");
AST_SAME: assert property (o_group3_first_output == o_group3_second_output && o_group3_second_output == o_group3_third_output)
    else $error("group outputs differ");
AST_DCC: assert property (ok |-> o_duty_cycle_correction_en == !ctl_r[0])
    else $error("correction enable");
AST_DCC_PREV: assert property (ok |-> o_ch2_duty_cycle_correction_en == !prv_r[0])
    else $error("preceding correction enable");
AST_VCO: assert property (ok |-> o_vco_divider_bypass == ckn_r[0])
    else $error("divider bypass copy");
AST_STATIC: assert property (stat |-> o_group3_first_output == (div_r[5] & div_r[4]))
    else $error("static level");
endmodule

// ===== sim/output_channel_divider_bench.sv
// Self-checking bench for the channel divider.
`timescale 1ns/100ps
module output_channel_divider_bench;
logic i_clk_sys = 0, i_nrst = 0, i_reg_wr = 0, i_reg_rd = 0, i_sync_n = 1;
logic [9:0] i_reg_addr = 0;
logic [7:0] i_reg_wdata = 0, o_reg_rdata, lo, hi, n0, n3;
logic [2:0] dc = 0;
logic o_reg_rvalid, o_group3_first_output, o_group3_second_output, o_group3_third_output;
logic o_group3_power_down, o_duty_cycle_correction_en, o_ch2_duty_cycle_correction_en;
logic o_vco_divider_bypass;
logic [9:0] ra [5] = '{10'h198, 10'h199, 10'h19a, 10'h19b, 10'h1e1};
logic [7:0] wm [5] = '{8'h01, 8'hff, 8'hff, 8'h07, 8'h01};
int fail_count = 0, checks = 0;
always #12.5 i_clk_sys = ~i_clk_sys;
// ----
// Stimulus
// ----
// The distribution clock runs at an eighth of the system clock, inside the synchroniser limit.
always @(posedge i_clk_sys) dc <= dc + 3'h1;
output_channel_divider i_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_dist_clk(dc[2]),
    .i_sync_n(i_sync_n), .o_group3_first_output(o_group3_first_output),
    .o_group3_second_output(o_group3_second_output),
    .o_group3_third_output(o_group3_third_output), .o_group3_power_down(o_group3_power_down),
    .o_duty_cycle_correction_en(o_duty_cycle_correction_en),
    .o_ch2_duty_cycle_correction_en(o_ch2_duty_cycle_correction_en),
    .o_vco_divider_bypass(o_vco_divider_bypass));
task finish_test;
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
        fail_count++;
        $display("ERROR %s expected %h seen %h", s, e, g);
    end
endtask
task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
endtask
task rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(negedge i_clk_sys);
    chk("read data", e, o_reg_rvalid === 1'b1 ? o_reg_rdata : 8'hxx);
endtask
task wt(input logic v, output logic [7:0] n);
    n = 0;
    while (o_group3_first_output !== v && n < 8'd200) begin
        @(negedge i_clk_sys);
        n++;
    end
endtask
task meas;
    wt(1'b1, lo);
    wt(1'b0, lo);
    wt(1'b1, lo);
    wt(1'b0, hi);
endtask
task ph(input logic [3:0] p, output logic [7:0] n);
    @(posedge i_clk_sys);
    i_sync_n <= 1'b0;
    wr(10'h19a, {4'h0, p});
    repeat (20) @(negedge i_clk_sys);
    while (dc !== 3'h7) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    i_sync_n <= 1'b1;
    wt(1'b1, n);
endtask
initial begin
    repeat (20000) @(posedge i_clk_sys);
    fail_count++;
    finish_test;
end
initial begin
    repeat (3) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00);
    foreach (ra[i]) begin
        wr(ra[i], 8'hff);
        rd(ra[i], wm[i]);
    end
    wr(10'h000, 8'hff);
    rd(10'h000, 8'h00);
    repeat (4) @(negedge i_clk_sys);
    chk("correction enable", 8'h00, {7'h0, o_duty_cycle_correction_en});
    chk("prev correction enable", 8'h00, {7'h0, o_ch2_duty_cycle_correction_en});
    chk("vco bypass", 8'h01, {7'h0, o_vco_divider_bypass});
    chk("power-down", 8'h01, {7'h0, o_group3_power_down});
    wr(10'h19b, 8'h00);
    wr(10'h1e1, 8'h00);
    wr(10'h199, 8'h12);
    wr(10'h19a, 8'h00);
    meas;
    chk("low time", 8'd16, lo);
    chk("high time", 8'd24, hi);
    // Ignore-sync is set as well, so an honoured force bit would freeze the output.
    wr(10'h19a, 8'he0);
    meas;
    chk("bypass half", 8'd4, lo);
    chk("bypass half", 8'd4, hi);
    wr(10'h19a, 8'h00);
    wr(10'h19b, 8'h02);
    meas;
    chk("direct half", 8'd4, lo);
    wr(10'h1e1, 8'h01);
    meas;
    chk("direct inert", 8'd16, lo);
    @(posedge i_clk_sys);
    i_sync_n <= 1'b0;
    wr(10'h19a, 8'h10);
    repeat (10) @(negedge i_clk_sys);
    wt(1'b0, n0);
    chk("sync hold", 8'd200, n0);
    wr(10'h19a, 8'h70);
    i_sync_n <= 1'b1;
    repeat (10) @(negedge i_clk_sys);
    wt(1'b0, n0);
    chk("forced high", 8'd200, n0);
    wr(10'h19a, 8'h50);
    repeat (10) @(negedge i_clk_sys);
    chk("forced low", 8'h00, {7'h0, o_group3_first_output});
    wr(10'h199, 8'h00);
    ph(4'h0, n0);
    ph(4'h3, n3);
    chk("phase offset", 8'd24, n3 - n0);
    finish_test;
end
endmodule
bind output_channel_divider output_channel_divider_monitor i_mon (.i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_dist_clk(i_dist_clk), .i_sync_n(i_sync_n),
    .o_group3_first_output(o_group3_first_output),
    .o_group3_second_output(o_group3_second_output),
    .o_group3_third_output(o_group3_third_output), .o_group3_power_down(o_group3_power_down),
    .o_duty_cycle_correction_en(o_duty_cycle_correction_en),
    .o_ch2_duty_cycle_correction_en(o_ch2_duty_cycle_correction_en),
    .o_vco_divider_bypass(o_vco_divider_bypass));
